//--- inc/iogc_map.vh
// Purpose: Register map and field layout of the expander and event-pin control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   Definitions only
`ifndef IOGC_MAP_VH
`define IOGC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IOGC_OFS_EXP_CTRL      12'h430
`define IOGC_OFS_ADDR_LOW      12'h434
`define IOGC_OFS_ADDR_HIGH     12'h438
`define IOGC_OFS_EVT_CTRL      12'h450
`define IOGC_OFS_IRQ_STATUS    12'h470
`define IOGC_OFS_IRQ_MASK      12'h474

// ----------------------------------------------------------------
// Expander control/status fields
// ----------------------------------------------------------------
`define IOGC_DATA_MSB          15
`define IOGC_RELOAD_BIT        24
`define IOGC_TEST_BIT          25
`define IOGC_SEL_MSB           29
`define IOGC_SEL_LSB           26
`define IOGC_DONE_BIT          31
`define IOGC_SEL_LAST          4'h4

// ----------------------------------------------------------------
// Operation kinds handed to the SMBus master engine
// ----------------------------------------------------------------
`define IOGC_OP_RELOAD         2'h1
`define IOGC_OP_UPDATE         2'h2
`define IOGC_OP_INIT           2'h3

// ----------------------------------------------------------------
// Interrupt status bits, reset values
// ----------------------------------------------------------------
`define IOGC_IRQ_DONE_BIT      0
`define IOGC_IRQ_EVENT_BIT     1
`define IOGC_RST_WORD          32'h0000_0000
`define IOGC_RST_ADDR7         7'h00
`define IOGC_RST_EVT           6'h00

`endif

//--- hw/iogc_regs.v
// Purpose: Expander control, expander bus addresses and general event pin control
// Assumes: One clock hclk at 200 MHz; all side inputs come from logic on hclk
// Notes:   AHB-Lite slave, writes zero wait, reads one wait state
`timescale 1ns/1ps
`include "iogc_map.vh"

// What this block does
// - Control bit 31 is a completion flag, reset zero, hardware set, write-one clears.
// - Reload request on selected expander sets the flag when the refresh finishes.
// - In test mode a data write sends an output update; flag sets when done.
// - Writing the selected expander's address starts its init; flag sets when done.
// - Address low register: expander 0 in bits 7:1, expander 1 in 15:9.
// - Address low register: expander 2 in bits 23:17, expander 3 in 31:25.
// - Address high register: expander 4 in bits 7:1, all other bits zero.
// - Address fields reset zero, sticky, and writable only while unlocked.
// - Event-control bit 0 sets pin polarity: 0 active low, 1 active high.
// - Port enable bits 1-5 divert hot-plug INTx/MSI/PME notices to the event pin.
// - The event output leaves on general-purpose pin 7 as alternate function.
// - Polarity and divert bits reset zero, sticky; bits 31:6 read zero.
// - Select field 29:26 picks expander 0 to 4; higher codes do nothing.
// - Writing one to reload bit 24 refreshes the selected expander; reads zero.
// - Test mode bit 25 sends written data instead of core-generated outputs.
module iogc_regs (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        reg_lock,
   input  wire [15:0] core_pin_values,
   input  wire [15:0] exp_read_values,
   input  wire        exp_op_done,
   output reg         exp_op_start_r,
   output reg  [1:0]  exp_op_kind_r,
   output reg  [2:0]  exp_op_sel_r,
   output reg  [6:0]  exp_op_addr_r,
   output reg  [15:0] exp_out_values_r,
   input  wire [4:0]  port_hp_event,
   output reg  [4:0]  port_hp_notify_r,
   output reg         gpio7_alt_out_r,
   output reg         irq_r
);

   // ----------------------------------------------------------------
   // Engine states
   // ----------------------------------------------------------------
   localparam ST_IDLE = 2'b01;
   localparam ST_BUSY = 2'b10;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [1:0]  state_r;
   reg [15:0] pin_values_r;
   reg        test_mode_r;
   reg [3:0]  select_r;
   reg        done_r;
   reg [6:0]  exp_addr_r [0:4];
   reg        polarity_r;
   reg [4:0]  divert_r;
   reg [1:0]  irq_status_r;
   reg [1:0]  irq_mask_r;
   reg        wr_pend_r;
   reg        rd_pend_r;
   reg [11:0] ph_addr_r;
   reg        evt_seen_r;

   wire        addr_ok;
   wire        take;
   wire        do_wr;
   wire        wr_ctrl;
   wire        wr_low;
   wire        wr_high;
   wire        wr_evt;
   wire        wr_mask;
   wire [3:0]  wr_sel;
   wire        sel_valid_new;
   wire        sel_valid_cur;
   wire        req_reload;
   wire        req_update;
   wire        req_init;
   wire        start;
   wire        finish;
   wire        done_set;
   wire        evt_any;
   wire        rd_status;
   reg  [31:0] rd_mux;
   reg  [1:0]  start_kind;
   integer     i;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Address phase accepted on a valid NONSEQ or SEQ with hready high
   assign take    = hsel & hready & htrans[1];
   assign addr_ok = 1'b1;
   assign do_wr   = wr_pend_r;
   assign wr_ctrl = do_wr & (ph_addr_r == `IOGC_OFS_EXP_CTRL);
   assign wr_low  = do_wr & (ph_addr_r == `IOGC_OFS_ADDR_LOW);
   assign wr_high = do_wr & (ph_addr_r == `IOGC_OFS_ADDR_HIGH);
   assign wr_evt  = do_wr & (ph_addr_r == `IOGC_OFS_EVT_CTRL);
   assign wr_mask = do_wr & (ph_addr_r == `IOGC_OFS_IRQ_MASK);
   // Status read clears on the edge that returns its data
   assign rd_status = rd_pend_r & (ph_addr_r == `IOGC_OFS_IRQ_STATUS);

   // ----------------------------------------------------------------
   // Operation requests
   // ----------------------------------------------------------------
   // Select code above four names no expander and starts nothing
   assign wr_sel        = hwdata[`IOGC_SEL_MSB:`IOGC_SEL_LSB];
   assign sel_valid_new = (wr_sel <= `IOGC_SEL_LAST);
   assign sel_valid_cur = (select_r <= `IOGC_SEL_LAST);
   assign req_reload = wr_ctrl & hwdata[`IOGC_RELOAD_BIT] & sel_valid_new;
   assign req_update = wr_ctrl & test_mode_r & sel_valid_new;
   // Init only when the written word holds the selected expander's field
   assign req_init = ~reg_lock & sel_valid_cur &
                     ((wr_low & (select_r < 4'h4)) |
                      (wr_high & (select_r == 4'h4)));
   assign start    = (state_r == ST_IDLE) & (req_reload | req_update | req_init);
   assign finish   = (state_r == ST_BUSY) & exp_op_done;
   assign done_set = finish;

   // Reload wins over update, update over init
   always @* begin
      if (req_reload) begin
         start_kind = `IOGC_OP_RELOAD;
      end else if (req_update) begin
         start_kind = `IOGC_OP_UPDATE;
      end else begin
         start_kind = `IOGC_OP_INIT;
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave handshake
   // ----------------------------------------------------------------
   // Reads stall one cycle so data reflects any write just completed
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         ph_addr_r <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= `IOGC_RST_WORD;
      end else begin
         hresp <= 1'b0;
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= rd_mux;
         end else begin
            wr_pend_r <= take & hwrite & addr_ok;
            rd_pend_r <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            if (take) begin
               ph_addr_r <= {haddr[11:2], 2'b00};
            end
         end
      end
   end

   // Read data selection, unmapped and reserved bits read zero
   always @* begin
      rd_mux = `IOGC_RST_WORD;
      case (ph_addr_r)
         `IOGC_OFS_EXP_CTRL: begin
            rd_mux[`IOGC_DATA_MSB:0]             = pin_values_r;
            rd_mux[`IOGC_TEST_BIT]               = test_mode_r;
            rd_mux[`IOGC_SEL_MSB:`IOGC_SEL_LSB]  = select_r;
            rd_mux[`IOGC_DONE_BIT]               = done_r;
         end
         `IOGC_OFS_ADDR_LOW: begin
            rd_mux = {exp_addr_r[3], 1'b0, exp_addr_r[2], 1'b0,
                      exp_addr_r[1], 1'b0, exp_addr_r[0], 1'b0};
         end
         `IOGC_OFS_ADDR_HIGH: begin
            rd_mux[7:0] = {exp_addr_r[4], 1'b0};
         end
         `IOGC_OFS_EVT_CTRL: begin
            rd_mux[5:0] = {divert_r, polarity_r};
         end
         `IOGC_OFS_IRQ_STATUS: begin
            rd_mux[1:0] = irq_status_r;
         end
         `IOGC_OFS_IRQ_MASK: begin
            rd_mux[1:0] = irq_mask_r;
         end
         default: begin
            rd_mux = `IOGC_RST_WORD;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Expander control/status register
   // ----------------------------------------------------------------
   // Data field takes writes only in test mode; reload refreshes it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_values_r <= 16'h0000;
         test_mode_r  <= 1'b0;
         select_r     <= 4'h0;
         done_r       <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            test_mode_r <= hwdata[`IOGC_TEST_BIT];
            select_r    <= wr_sel;
            if (test_mode_r) begin
               pin_values_r <= hwdata[`IOGC_DATA_MSB:0];
            end
         end
         if (finish & (exp_op_kind_r == `IOGC_OP_RELOAD)) begin
            pin_values_r <= exp_read_values;
         end
         // Completion beats a coincident write-one clear
         if (done_set) begin
            done_r <= 1'b1;
         end else if (wr_ctrl & hwdata[`IOGC_DONE_BIT]) begin
            done_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Expander bus addresses
   // ----------------------------------------------------------------
   // Writes land only while the register lock is released
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < 5; i = i + 1) begin
            exp_addr_r[i] <= `IOGC_RST_ADDR7;
         end
      end else if (!reg_lock) begin
         if (wr_low) begin
            exp_addr_r[0] <= hwdata[7:1];
            exp_addr_r[1] <= hwdata[15:9];
            exp_addr_r[2] <= hwdata[23:17];
            exp_addr_r[3] <= hwdata[31:25];
         end
         if (wr_high) begin
            exp_addr_r[4] <= hwdata[7:1];
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer towards the SMBus master engine
   // ----------------------------------------------------------------
   // One operation at a time; requests while busy are dropped
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r          <= ST_IDLE;
         exp_op_start_r   <= 1'b0;
         exp_op_kind_r    <= 2'h0;
         exp_op_sel_r     <= 3'h0;
         exp_op_addr_r    <= 7'h00;
      end else begin
         exp_op_start_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r        <= ST_BUSY;
                  exp_op_start_r <= 1'b1;
                  exp_op_kind_r  <= start_kind;
                  if (req_init & ~req_reload & ~req_update) begin
                     exp_op_sel_r  <= select_r[2:0];
                     exp_op_addr_r <= (select_r == 4'h4) ? hwdata[7:1] :
                                      hwdata[{select_r[1:0], 3'b001} +: 7];
                  end else begin
                     exp_op_sel_r  <= wr_sel[2:0];
                     exp_op_addr_r <= exp_addr_r[wr_sel[2:0]];
                  end
               end
            end
            ST_BUSY: begin
               if (exp_op_done) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Output values: core values unless test mode substitutes written data
   // A test-mode data write loads the word at once, so the update started
   // by that same write carries the new value and not the previous one
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exp_out_values_r <= 16'h0000;
      end else if (wr_ctrl & test_mode_r) begin
         exp_out_values_r <= hwdata[`IOGC_DATA_MSB:0];
      end else begin
         exp_out_values_r <= test_mode_r ? pin_values_r : core_pin_values;
      end
   end

   // ----------------------------------------------------------------
   // General event control and pin
   // ----------------------------------------------------------------
   // Sticky polarity and per-port divert enables
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         polarity_r <= 1'b0;
         divert_r   <= 5'h00;
      end else if (wr_evt) begin
         polarity_r <= hwdata[0];
         divert_r   <= hwdata[5:1];
      end
   end

   assign evt_any = |(port_hp_event & divert_r);

   // Diverted ports lose their normal notice and drive GPIO 7 instead
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_hp_notify_r <= 5'h00;
         gpio7_alt_out_r  <= 1'b1;
         evt_seen_r       <= 1'b0;
      end else begin
         port_hp_notify_r <= port_hp_event & ~divert_r;
         gpio7_alt_out_r  <= polarity_r ? evt_any : ~evt_any;
         evt_seen_r       <= evt_any;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------------------------------
   // Status clears on read; a new event in that cycle stays set
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_r <= 2'b00;
         irq_mask_r   <= 2'b00;
         irq_r        <= 1'b0;
      end else begin
         irq_status_r[`IOGC_IRQ_DONE_BIT] <= done_set |
            (irq_status_r[`IOGC_IRQ_DONE_BIT] & ~rd_status);
         irq_status_r[`IOGC_IRQ_EVENT_BIT] <= (evt_any & ~evt_seen_r) |
            (irq_status_r[`IOGC_IRQ_EVENT_BIT] & ~rd_status);
         if (wr_mask) begin
            irq_mask_r <= hwdata[1:0];
         end
         irq_r <= |(irq_status_r & irq_mask_r);
      end
   end

endmodule // iogc_regs

//--- testbench/iogc_chk.sv
// Purpose: Port assertions for the expander and event pin control registers
// Assumes: One clock hclk, reset hresetn async active low
// Notes:   Bound to iogc_regs from the testbench top file
`timescale 1ns/1ps
module iogc_chk (
   input wire       hclk,
   input wire       hresetn,
   input wire       hsel,
   input wire [1:0] htrans,
   input wire       hwrite,
   input wire       hready,
   input wire       hreadyout,
   input wire       hresp,
   input wire       exp_op_start_r,
   input wire [1:0] exp_op_kind_r,
   input wire [2:0] exp_op_sel_r,
   input wire [4:0] port_hp_event,
   input wire [4:0] port_hp_notify_r
);
   // ------------------------------------------------------------
   // Bus, engine and port notice checks
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Accepted read and write requests, read answer after one wait
   sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
   sequence s_wr; hsel && hready && htrans[1] && hwrite; endsequence
   sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
   a_read_wait: assert property (s_rd |=> s_rd_ans)
      else $error("read answer not after one wait state");
   a_write_nowait: assert property (s_wr |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response given");
   a_start_single: assert property (exp_op_start_r |=> !exp_op_start_r)
      else $error("op start longer than one cycle");
   a_start_cause: assert property (exp_op_start_r |->
      $past(hsel && hready && htrans[1] && hwrite, 2))
      else $error("op start without a write two cycles before");
   a_kind_legal: assert property (exp_op_start_r |-> exp_op_kind_r != 2'h0)
      else $error("op started with no kind");
   a_sel_range: assert property (exp_op_start_r |-> exp_op_sel_r <= 3'h4)
      else $error("op started on a reserved expander code");
   a_kind_hold: assert property ($changed(exp_op_kind_r) |-> exp_op_start_r)
      else $error("op kind changed outside a start");
   a_notify_src: assert property ((port_hp_notify_r & ~$past(port_hp_event)) == 5'h00)
      else $error("notice raised without a port request");
endmodule // iogc_chk

//--- testbench/iogc_engine_model.sv
// Purpose: Behavioural SMBus master engine with its expanders
// Assumes: Runs on hclk; answers each start after dly+1 cycles
// Notes:   Captures kind, select, address and output values of each op
`timescale 1ns/1ps
module iogc_engine_model (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        exp_op_start_r,
   input  wire [1:0]  exp_op_kind_r,
   input  wire [2:0]  exp_op_sel_r,
   input  wire [6:0]  exp_op_addr_r,
   input  wire [15:0] exp_out_values_r,
   input  wire [3:0]  dly,
   output reg         exp_op_done,
   output wire [15:0] exp_read_values,
   output reg  [27:0] cap_r,
   output reg  [7:0]  ops_r
);
   // ------------------------------------------------------------
   // Transaction timing
   // ------------------------------------------------------------
   reg [4:0] cnt_r;
   // Input pin values returned by the expander last addressed
   assign exp_read_values = {8'hA5, 5'h00, cap_r[25:23]};
   // Capture the op, then signal its end after the chosen delay
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 5'h00;
         exp_op_done <= 1'b0;
         cap_r <= 28'h0000000;
         ops_r <= 8'h00;
      end else begin
         exp_op_done <= (cnt_r == 5'h01);
         if (exp_op_start_r) begin
            cap_r <= {exp_op_kind_r, exp_op_sel_r, exp_op_addr_r, exp_out_values_r};
            cnt_r <= {1'b0, dly} + 5'h01;
         end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
         end
         if (cnt_r == 5'h01) ops_r <= ops_r + 8'h01; // Count finished ops
      end
   end
endmodule // iogc_engine_model

//--- testbench/iogc_regs_tb_top.sv
// Purpose: Self-checking bench for the expander and event pin control registers
// Assumes: AHB-Lite single word transfers, engine model on the far side
// Notes:   Ends with a verdict line from conclude
`timescale 1ns/1ps
module iogc_regs_tb_top;
   reg         hclk;
   reg         hresetn;
   reg         hsel;
   reg  [31:0] haddr;
   reg  [1:0]  htrans;
   reg         hwrite;
   reg  [31:0] hwdata;
   reg         reg_lock;
   reg  [15:0] core_pin_values;
   reg  [4:0]  port_hp_event;
   reg  [3:0]  dly;
   reg  [31:0] q;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, exp_op_done, exp_op_start_r, gpio7_alt_out_r, irq_r;
   wire [1:0]  exp_op_kind_r;
   wire [2:0]  exp_op_sel_r;
   wire [6:0]  exp_op_addr_r;
   wire [15:0] exp_out_values_r, exp_read_values;
   wire [4:0]  port_hp_notify_r;
   wire [27:0] cap;
   wire [7:0]  ops;
   integer     num_errors, checked, n, i;
   // ------------------------------------------------------------
   // Design, engine model, clock
   // ------------------------------------------------------------
   iogc_regs iogc_regs_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reg_lock(reg_lock),
      .core_pin_values(core_pin_values), .exp_read_values(exp_read_values),
      .exp_op_done(exp_op_done), .exp_op_start_r(exp_op_start_r),
      .exp_op_kind_r(exp_op_kind_r), .exp_op_sel_r(exp_op_sel_r),
      .exp_op_addr_r(exp_op_addr_r), .exp_out_values_r(exp_out_values_r),
      .port_hp_event(port_hp_event), .port_hp_notify_r(port_hp_notify_r),
      .gpio7_alt_out_r(gpio7_alt_out_r), .irq_r(irq_r));
   iogc_engine_model iogc_engine_model_inst (
      .hclk(hclk), .hresetn(hresetn), .exp_op_start_r(exp_op_start_r),
      .exp_op_kind_r(exp_op_kind_r), .exp_op_sel_r(exp_op_sel_r),
      .exp_op_addr_r(exp_op_addr_r), .exp_out_values_r(exp_out_values_r), .dly(dly),
      .exp_op_done(exp_op_done), .exp_read_values(exp_read_values), .cap_r(cap),
      .ops_r(ops));
   // 200 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // Value compare, counted
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One AHB-Lite single transfer; read data left in q
   task xfer(input w, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= a;
         hwrite <= w;
         htrans <= 2'h2;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         q = hrdata;
      end
   endtask
   task wr(input [31:0] a, input [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input [31:0] a, input [31:0] e);
      begin
         xfer(1'b0, a, 32'h00000000);
         chk(q, e);
      end
   endtask
   // Wait until the engine has finished one more op
   task wait_op(input [7:0] n0);
      begin
         while (ops == n0) @(posedge hclk);
         @(posedge hclk);
      end
   endtask
   task conclude;
      begin
         $display("Counts: %0d checks, %0d errors", checked, num_errors);
         if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask
   // Watchdog against a hung handshake
   initial begin
      #100000;
      num_errors = num_errors + 1;
      $display("Error at %0t: watchdog expired", $time);
      conclude;
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hwdata = 32'h0; reg_lock = 1'b0; core_pin_values = 16'h5A5A;
      port_hp_event = 5'h00; dly = 4'h0; num_errors = 0; checked = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(32'h430, 32'h00000000);
      rd(32'h434, 32'h00000000);
      rd(32'h438, 32'h00000000);
      rd(32'h450, 32'h00000000);
      rd(32'h440, 32'h00000000);
      $display("Test reset values done");
      n = ops;
      wr(32'h434, 32'hFFFFFFFF);
      wait_op(n);
      chk(cap[27:16], {2'h3, 3'h0, 7'h7F});
      rd(32'h434, 32'hFEFEFEFE);
      rd(32'h430, 32'h80000000);
      wr(32'h438, 32'hFFFFFFFF);
      rd(32'h438, 32'h000000FE);
      chk(ops, n + 1);
      reg_lock <= 1'b1;
      wr(32'h434, 32'h00000000);
      rd(32'h434, 32'hFEFEFEFE);
      chk(ops, n + 1);
      reg_lock <= 1'b0;
      wr(32'h434, 32'h02040608);
      wait_op(n + 1);
      chk(cap[22:16], 7'h04);
      wr(32'h438, 32'h0000000A);
      wr(32'h430, 32'h80000000);
      rd(32'h430, 32'h00000000);
      $display("Test address fields done");
      for (i = 0; i < 6; i = i + 1) begin
         n = ops;
         dly <= i[3:0] * 4'h3;
         wr(32'h430, 32'h01000000 | (i << 26));
         if (i < 5) begin
            wait_op(n);
            chk(cap[27:23], {2'h1, i[2:0]});
            chk(cap[22:16], (i < 4) ? 4 - i : 5);
            rd(32'h430, 32'h8000A500 | (i << 26) | i);
            wr(32'h430, 32'h80000000 | (i << 26));
         end else begin
            repeat (20) @(posedge hclk);
            chk(ops, n);
         end
      end
      $display("Test reload done");
      chk(exp_out_values_r, 16'h5A5A);
      wr(32'h430, 32'h8A000000);
      n = ops;
      wr(32'h430, 32'h0A001234);
      wait_op(n);
      chk(cap[27:23], {2'h2, 3'h2});
      chk(cap[15:0], 16'h1234);
      rd(32'h430, 32'h8A001234);
      n = ops;
      wr(32'h430, 32'h88000000);
      wait_op(n);
      wr(32'h430, 32'h80000000);
      $display("Test output update done");
      wr(32'h450, 32'hFFFFFFFF);
      rd(32'h450, 32'h0000003F);
      port_hp_event <= 5'h04;
      repeat (2) @(posedge hclk);
      chk(gpio7_alt_out_r, 1'b1);
      chk(port_hp_notify_r, 5'h00);
      wr(32'h450, 32'h0000003E);
      repeat (2) @(posedge hclk);
      chk(gpio7_alt_out_r, 1'b0);
      wr(32'h450, 32'h00000000);
      repeat (2) @(posedge hclk);
      chk(gpio7_alt_out_r, 1'b1);
      chk(port_hp_notify_r, 5'h04);
      $display("Test event pin done");
      chk(irq_r, 1'b0);
      wr(32'h474, 32'h00000003);
      repeat (2) @(posedge hclk);
      chk(irq_r, 1'b1);
      rd(32'h470, 32'h00000003);
      repeat (2) @(posedge hclk);
      chk(irq_r, 1'b0);
      wr(32'h474, 32'h00000002);
      n = ops;
      wr(32'h430, 32'h01000000);
      wait_op(n);
      repeat (2) @(posedge hclk);
      chk(irq_r, 1'b0);
      rd(32'h470, 32'h00000001);
      $display("Test interrupt done");
      conclude;
   end
endmodule // iogc_regs_tb_top
bind iogc_regs iogc_chk iogc_chk_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .exp_op_start_r(exp_op_start_r), .exp_op_kind_r(exp_op_kind_r),
   .exp_op_sel_r(exp_op_sel_r), .port_hp_event(port_hp_event),
   .port_hp_notify_r(port_hp_notify_r));
